// ### rtl/upcs_pkg.sv
// Package for the USB power and charger signalling block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
`default_nettype none
package upcs_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CODES  = 12'h008;
  localparam logic [11:0] OFS_LEDCFG = 12'h00C;

  // Control register fields
  localparam int unsigned CTRL_BCD_EN   = 0;
  localparam int unsigned CTRL_SENSE_EN = 1;
  localparam int unsigned CTRL_CONFIG   = 2;
  localparam int unsigned CTRL_SUSPEND  = 3;
  localparam int unsigned CTRL_LDE_EN   = 4;
  localparam int unsigned CTRL_LED_EN   = 5;
  localparam int unsigned CTRL_WAKE_POL = 6;
  localparam int unsigned CTRL_TX_AVAIL = 7;
  localparam int unsigned CTRL_RX_PULSE = 8;
  localparam int unsigned CTRL_TX_PULSE = 9;
  localparam int unsigned CTRL_W        = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

  // Charger code field positions in the code register
  localparam int unsigned CODE_NONE = 0;
  localparam int unsigned CODE_SDP  = 2;
  localparam int unsigned CODE_CDP  = 4;
  localparam int unsigned CODE_SUSP = 6;
  localparam logic [7:0] CODES_RST = 8'hE4;

  // LED pulse length in cycles
  localparam logic [15:0] LED_PULSE_RST = 16'h03E8;

  // Charger port kinds, reported in status
  localparam logic [1:0] PORT_NONE = 2'h0;
  localparam logic [1:0] PORT_SDP  = 2'h1;
  localparam logic [1:0] PORT_CDP  = 2'h2;
  localparam logic [1:0] PORT_DCP  = 2'h3;

  // Detection settle time (us) and cycle count
  localparam int unsigned DET_TIME_US  = 100;
  localparam int unsigned DET_CYCLES   = DET_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } upcs_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } upcs_apb_rsp_t;

  typedef enum logic [1:0] {
    ST_DETACHED,
    ST_DETECT,
    ST_ATTACHED
  } upcs_state_t;

endpackage
`default_nettype wire

// ### rtl/upcs_sync.sv
// Three-stage input synchroniser with agreement check.
// Assumes the input is asynchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module upcs_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  output var  logic level_o
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       level_r;
  logic       level_nxt;

  always_comb begin
    stage_nxt = {stage_r[1:0], async_i};
    level_nxt = level_r;
    // Second and third stages agree
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_r <= {3{RST_VAL}};
      level_r <= RST_VAL;
    end else begin
      stage_r <= stage_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule // upcs_sync
`default_nettype wire

// ### rtl/upcs_led.sv
// Activity LED pulse stretcher, active-low output.
// Assumes a one-cycle activity strobe on the system clock.
`timescale 1ns/100ps
`default_nettype none
module upcs_led (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        enable_i,
  input  wire logic        strobe_i,
  input  wire logic [15:0] length_i,
  output var  logic        led_n_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        led_n_r;
  logic        led_n_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!enable_i) begin
      cnt_nxt = '0;
    end else if (strobe_i) begin
      cnt_nxt = length_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 16'h0001;
    end
    led_n_nxt = (cnt_nxt == '0);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r   <= '0;
      led_n_r <= 1'b1;
    end else begin
      cnt_r   <= cnt_nxt;
      led_n_r <= led_n_nxt;
    end
  end

  assign led_n_o = led_n_r;

endmodule // upcs_led
`default_nettype wire

// ### rtl/upcs_top.sv
// USB power, pull-up and charger-type signalling with an APB register file.
// Assumes pins are asynchronous; the USB core and UART sit on clk_sys_i.
//
// Operation
// RULE_01: Pull-up on D+ is enabled while bus voltage is present.
// RULE_02: Pull-up is removed when bus voltage is absent.
// RULE_03: All pin outputs are released while chip reset is asserted.
// RULE_04: External system uses power-switch output to cut load current.
// RULE_05: Suspend output flags link suspend or enumeration not complete.
// RULE_06: Line driver enable follows transmit character availability when enabled.
// RULE_07: Wake-up input in suspend raises a remote wakeup request.
// RULE_08: Bus voltage arrival starts charger detection; result on two outputs.
// RULE_09: Pull-up only for standard or charging downstream ports.
// RULE_10: Bus voltage loss reports no charger and removes pull-up.
// RULE_11: Detection and bus sensing stay off until configured on.
// RULE_12: Bus presence is taken from the configurable sense input.
// RULE_13: External system limits current per reported charger type.
// RULE_14: Active-low receive and transmit LEDs pulse on activity.
// RULE_15: Charger outputs use configurable default code table.
// RULE_16: Power-switch output low when configured, high otherwise; the code also drives it high while suspended.
// RULE_17: Bus sense input is synchronised before use.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module upcs_top
  import upcs_pkg::*;
#(
  parameter int unsigned DET_CNT = upcs_pkg::DET_CYCLES
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  input  wire upcs_pkg::upcs_apb_req_t apb_req_i,
  output var  upcs_pkg::upcs_apb_rsp_t apb_rsp_o,
  input  wire logic                    vbus_sense_input_i,
  input  wire logic [1:0]              port_kind_i,
  input  wire logic                    wakeup_i,
  output var  logic                    dp_pullup_en_o,
  output var  logic                    charger_type_bit0_o,
  output var  logic                    charger_type_bit1_o,
  output var  logic                    power_switch_n_o,
  output var  logic                    suspend_o,
  output var  logic                    remote_wakeup_o,
  output var  logic                    line_driver_enable_o,
  output var  logic                    rx_activity_led_n_o,
  output var  logic                    tx_activity_led_n_o,
  output var  logic                    pin_oe_n_o
);
  import upcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic vbus_sync;
  logic wake_sync;
  logic [1:0] kind_sync;

  upcs_sync #(.RST_VAL(1'b0)) u_sync_vbus (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   (vbus_sense_input_i),
    .level_o   (vbus_sync)
  ); // RULE_17

  upcs_sync #(.RST_VAL(1'b0)) u_sync_wake (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   (wakeup_i),
    .level_o   (wake_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_kind
      upcs_sync #(.RST_VAL(1'b0)) u_sync_kind (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .async_i   (port_kind_i[gi]),
        .level_o   (kind_sync[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [7:0]        codes_r;
  logic [7:0]        codes_nxt;
  logic [15:0]       led_len_r;
  logic [15:0]       led_len_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;
  logic              pready_r;
  logic              pready_nxt;
  logic              pslverr_r;
  logic              pslverr_nxt;
  logic              setup;
  logic              wr_en;
  logic              hit;
  logic [1:0]        kind_r;
  upcs_state_t       state_r;

  assign setup = apb_req_i.psel && !apb_req_i.penable;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    codes_nxt   = codes_r;
    led_len_nxt = led_len_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    wr_en       = apb_req_i.psel && apb_req_i.penable && pready_r && apb_req_i.pwrite;
    hit         = 1'b1;
    // Strobes are one-cycle pulses
    ctrl_nxt[CTRL_RX_PULSE] = 1'b0;
    ctrl_nxt[CTRL_TX_PULSE] = 1'b0;
    if (setup) begin
      pready_nxt = 1'b1;
      prdata_nxt = '0;
      case (apb_req_i.paddr)
        OFS_CTRL: begin
          prdata_nxt[CTRL_W-1:0] = ctrl_r;
        end
        OFS_STATUS: begin
          prdata_nxt[7:0] = {kind_r, remote_wakeup_o, suspend_o,
                             vbus_sync, state_r == ST_ATTACHED,
                             charger_type_bit1_o, charger_type_bit0_o};
        end
        OFS_CODES: begin
          prdata_nxt[7:0] = codes_r;
        end
        OFS_LEDCFG: begin
          prdata_nxt[15:0] = led_len_r;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      pslverr_nxt = !hit;
    end
    // Writes land on the access edge that sees pready high
    if (wr_en) begin
      case (apb_req_i.paddr)
        OFS_CTRL:   ctrl_nxt    = apb_req_i.pwdata[CTRL_W-1:0];
        OFS_CODES:  codes_nxt   = apb_req_i.pwdata[7:0]; // RULE_15
        OFS_LEDCFG: led_len_nxt = apb_req_i.pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r    <= CTRL_RST; // RULE_11
      codes_r   <= CODES_RST;
      led_len_r <= LED_PULSE_RST;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      codes_r   <= codes_nxt;
      led_len_r <= led_len_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign apb_rsp_o.pready  = pready_r;
  assign apb_rsp_o.prdata  = prdata_r;
  assign apb_rsp_o.pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Charger detection sequence

  upcs_state_t state_nxt;
  logic [31:0] det_cnt_r;
  logic [31:0] det_cnt_nxt;
  logic [1:0]  kind_nxt;
  logic        vbus_ok;

  // Bus presence only counts when sensing is configured on
  assign vbus_ok = ctrl_r[CTRL_SENSE_EN] && vbus_sync; // RULE_12 RULE_11

  always_comb begin
    state_nxt   = state_r;
    det_cnt_nxt = det_cnt_r;
    kind_nxt    = kind_r;
    case (state_r)
      ST_DETACHED: begin
        kind_nxt    = PORT_NONE;
        det_cnt_nxt = '0;
        if (vbus_ok) begin
          if (ctrl_r[CTRL_BCD_EN]) begin
            state_nxt = ST_DETECT; // RULE_08
          end else begin
            kind_nxt  = PORT_SDP;
            state_nxt = ST_ATTACHED;
          end
        end
      end
      ST_DETECT: begin
        if (!vbus_ok) begin
          state_nxt = ST_DETACHED; // RULE_10
        end else if (det_cnt_r >= DET_CNT - 1) begin
          kind_nxt  = (kind_sync == PORT_NONE) ? PORT_SDP : kind_sync;
          state_nxt = ST_ATTACHED;
        end else begin
          det_cnt_nxt = det_cnt_r + 32'h0000_0001;
        end
      end
      ST_ATTACHED: begin
        if (!vbus_ok) begin
          kind_nxt  = PORT_NONE;
          state_nxt = ST_DETACHED; // RULE_10
        end
      end
      default: begin
        state_nxt = ST_DETACHED;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= ST_DETACHED;
      det_cnt_r <= '0;
      kind_r    <= PORT_NONE;
    end else begin
      state_r   <= state_nxt;
      det_cnt_r <= det_cnt_nxt;
      kind_r    <= kind_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  logic       pullup_nxt;
  logic [1:0] code_nxt;
  logic       pwr_nxt;
  logic       susp_nxt;
  logic       wake_nxt;
  logic       lde_nxt;
  logic       pullup_r;
  logic [1:0] code_r;
  logic       pwr_r;
  logic       susp_r;
  logic       wake_r;
  logic       lde_r;
  logic       oe_n_r;
  logic       wake_lvl;

  assign wake_lvl = wake_sync ^ ctrl_r[CTRL_WAKE_POL];

  always_comb begin
    // Pull-up only on an attached standard or charging downstream port
    pullup_nxt = vbus_ok && (state_r == ST_ATTACHED) &&
                 (kind_r == PORT_SDP || kind_r == PORT_CDP); // RULE_01 RULE_02 RULE_09
    susp_nxt = ctrl_r[CTRL_SUSPEND] || !ctrl_r[CTRL_CONFIG]; // RULE_05
    pwr_nxt  = !(ctrl_r[CTRL_CONFIG] && !ctrl_r[CTRL_SUSPEND]); // RULE_16
    if (!vbus_ok || state_r != ST_ATTACHED) begin
      code_nxt = codes_r[CODE_NONE +: 2]; // RULE_10
    end else if (ctrl_r[CTRL_SUSPEND]) begin
      code_nxt = codes_r[CODE_SUSP +: 2]; // RULE_15
    end else if (kind_r == PORT_SDP) begin
      code_nxt = codes_r[CODE_SDP +: 2];
    end else begin
      code_nxt = codes_r[CODE_CDP +: 2];
    end
    // Wake request held while suspended and wake asserted
    wake_nxt = ctrl_r[CTRL_SUSPEND] && wake_lvl; // RULE_07
    lde_nxt  = ctrl_r[CTRL_LDE_EN] && ctrl_r[CTRL_TX_AVAIL]; // RULE_06
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pullup_r <= 1'b0;
      code_r   <= 2'h0;
      pwr_r    <= 1'b1;
      susp_r   <= 1'b1;
      wake_r   <= 1'b0;
      lde_r    <= 1'b0;
      oe_n_r   <= 1'b1; // RULE_03
    end else begin
      pullup_r <= pullup_nxt;
      code_r   <= code_nxt;
      pwr_r    <= pwr_nxt;
      susp_r   <= susp_nxt;
      wake_r   <= wake_nxt;
      lde_r    <= lde_nxt;
      oe_n_r   <= 1'b0;
    end
  end

  assign dp_pullup_en_o       = pullup_r;
  assign charger_type_bit0_o  = code_r[0];
  assign charger_type_bit1_o  = code_r[1];
  assign power_switch_n_o     = pwr_r;
  assign suspend_o            = susp_r;
  assign remote_wakeup_o      = wake_r;
  assign line_driver_enable_o = lde_r;
  assign pin_oe_n_o           = oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Activity LEDs

  upcs_led u_led_rx (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .enable_i  (ctrl_r[CTRL_LED_EN]),
    .strobe_i  (ctrl_r[CTRL_RX_PULSE]),
    .length_i  (led_len_r),
    .led_n_o   (rx_activity_led_n_o)
  ); // RULE_14

  upcs_led u_led_tx (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .enable_i  (ctrl_r[CTRL_LED_EN]),
    .strobe_i  (ctrl_r[CTRL_TX_PULSE]),
    .length_i  (led_len_r),
    .led_n_o   (tx_activity_led_n_o)
  ); // RULE_14

endmodule // upcs_top
`default_nettype wire

// ### tb/upcs_chk_asserts.sv
// Checker for the power, pull-up and charger signalling block.
// Assumes the top module ports only; bound into upcs_top below.
`timescale 1ns/100ps
`default_nettype none
module upcs_chk
  import upcs_pkg::*;
#(
  parameter int unsigned DET_CNT = 4
) (
  input wire logic                    clk_sys_i,
  input wire logic                    nrst_i,
  input wire upcs_pkg::upcs_apb_req_t apb_req_i,
  input wire upcs_pkg::upcs_apb_rsp_t apb_rsp_o,
  input wire logic                    vbus_sense_input_i,
  input wire logic [1:0]              port_kind_i,
  input wire logic                    dp_pullup_en_o,
  input wire logic                    charger_type_bit0_o,
  input wire logic                    charger_type_bit1_o,
  input wire logic                    power_switch_n_o,
  input wire logic                    suspend_o,
  input wire logic                    remote_wakeup_o,
  input wire logic                    line_driver_enable_o,
  input wire logic                    pin_oe_n_o
);
  logic [9:0] ctl_r;
  logic [7:0] cod_r;
  logic [1:0] code;
  logic       wr;
  assign code = {charger_type_bit1_o, charger_type_bit0_o};
  assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & apb_rsp_o.pready;
  // Shadow of the control and code registers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_r <= 10'h000;
      cod_r <= 8'hE4;
    end else if (wr) begin
      if (apb_req_i.paddr == OFS_CTRL) ctl_r <= apb_req_i.pwdata[9:0];
      if (apb_req_i.paddr == OFS_CODES) cod_r <= apb_req_i.pwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_PIN_RELEASE: assert property ($rose(nrst_i) |-> pin_oe_n_o ##1 !pin_oe_n_o)
    else $error("pins not released in reset");
  AST_PULLUP_CAUSE: assert property ($rose(dp_pullup_en_o)
    |-> $past(vbus_sense_input_i, 4))
    else $error("pull-up without bus voltage");
  AST_PULLUP_GONE: assert property (!vbus_sense_input_i [*7] |-> !dp_pullup_en_o)
    else $error("pull-up kept after bus loss");
  AST_CODE_NONE: assert property ((!vbus_sense_input_i && $stable(cod_r)) [*7]
    |-> code == cod_r[1:0])
    else $error("charger code not none");
  AST_SENSE_OFF: assert property (!ctl_r[1] [*8] |-> !dp_pullup_en_o)
    else $error("pull-up with sensing off");
  AST_DCP_NOPULL: assert property ((port_kind_i == PORT_DCP && ctl_r[0]) [*8]
    |-> !dp_pullup_en_o)
    else $error("pull-up on dedicated charger");
  AST_PSW: assert property ($stable(ctl_r) [*3]
    |-> power_switch_n_o == !(ctl_r[2] && !ctl_r[3]))
    else $error("power switch level wrong");
  AST_SUSP: assert property ($stable(ctl_r) [*3]
    |-> suspend_o == (ctl_r[3] || !ctl_r[2]))
    else $error("suspend level wrong");
  AST_LDE: assert property ($stable(ctl_r) [*3]
    |-> line_driver_enable_o == (ctl_r[4] && ctl_r[7]))
    else $error("line driver enable wrong");
  AST_WAKE: assert property (remote_wakeup_o |-> suspend_o)
    else $error("wakeup outside suspend");
endmodule // upcs_chk
bind upcs_top upcs_chk #(.DET_CNT(DET_CNT)) u_chk (.clk_sys_i, .nrst_i, .apb_req_i, .apb_rsp_o,
  .vbus_sense_input_i, .port_kind_i, .dp_pullup_en_o, .charger_type_bit0_o,
  .charger_type_bit1_o, .power_switch_n_o, .suspend_o, .remote_wakeup_o,
  .line_driver_enable_o, .pin_oe_n_o);
`default_nettype wire

// ### tb/upcs_afe.sv
// Model of the bus supply and charger front end.
// Assumes the bench sets wanted levels and a reply lag in cycles.
`timescale 1ns/100ps
`default_nettype none
module upcs_afe (
  input  wire logic       clk_sys_i,
  input  wire logic       vbus_i,
  input  wire logic [1:0] kind_i,
  input  wire logic       wake_i,
  input  wire logic [3:0] lag_i,
  output var  logic       vbus_o,
  output var  logic [1:0] kind_o,
  output var  logic       wake_o
);
  logic [3:0] cnt = 4'h0;
  initial vbus_o = 1'b0;
  // Supply follows the wanted level after a lag
  always @(posedge clk_sys_i) begin
    cnt <= (vbus_i != vbus_o) ? cnt + 4'h1 : 4'h0;
    if (vbus_i != vbus_o && cnt >= lag_i) vbus_o <= vbus_i;
  end
  // Detector result pulled to none without supply
  assign kind_o = vbus_o ? kind_i : 2'h0;
  assign wake_o = wake_i;
endmodule // upcs_afe
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the power and charger signalling block.
// Assumes upcs_top, its package and the front end model.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import upcs_pkg::*;
  logic          clk_sys_i, nrst_i, vb, wk, rerr, bcd;
  upcs_apb_req_t apb_req_i;
  upcs_apb_rsp_t apb_rsp_o;
  logic          vbus_sense_input_i, wakeup_i, dp_pullup_en_o, charger_type_bit0_o;
  logic          charger_type_bit1_o, power_switch_n_o, suspend_o, remote_wakeup_o;
  logic          line_driver_enable_o, rx_activity_led_n_o, tx_activity_led_n_o, pin_oe_n_o;
  logic [1:0]    port_kind_i, kd, k, kx;
  logic [3:0]    lag;
  logic [7:0]    tbl, outs;
  logic [31:0]   rdat, d, r, pc, leds;
  integer        seed;
  int            failures, checks_done;
  assign pc = {29'h0, dp_pullup_en_o, charger_type_bit1_o, charger_type_bit0_o};
  assign leds = {30'h0, rx_activity_led_n_o, tx_activity_led_n_o};
  assign outs = {pin_oe_n_o, power_switch_n_o, suspend_o, rx_activity_led_n_o,
                 tx_activity_led_n_o, dp_pullup_en_o, remote_wakeup_o, line_driver_enable_o};
  upcs_top #(.DET_CNT(4)) dut (.clk_sys_i, .nrst_i, .apb_req_i, .apb_rsp_o,
    .vbus_sense_input_i, .port_kind_i, .wakeup_i, .dp_pullup_en_o, .charger_type_bit0_o,
    .charger_type_bit1_o, .power_switch_n_o, .suspend_o, .remote_wakeup_o,
    .line_driver_enable_o, .rx_activity_led_n_o, .tx_activity_led_n_o, .pin_oe_n_o);
  upcs_afe afe (.clk_sys_i, .vbus_i(vb), .kind_i(kd), .wake_i(wk), .lag_i(lag),
    .vbus_o(vbus_sense_input_i), .kind_o(port_kind_i), .wake_o(wakeup_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys_i) apb_req_i <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk_sys_i) apb_req_i.penable <= 1'b1;
    do @(posedge clk_sys_i); while (apb_rsp_o.pready !== 1'b1);
    rdat = apb_rsp_o.prdata;
    rerr = apb_rsp_o.pslverr;
    apb_req_i <= '0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  function automatic logic [31:0] exp_pc(input logic [7:0] t, input logic [1:0] kk,
                                         input logic att, input logic b);
    if (!att) return {30'h0, t[1:0]};
    if (!b) kk = PORT_SDP;
    return {29'h0, kk != PORT_DCP, kk[1] ? t[5:4] : t[3:2]};
  endfunction
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h1970;
    failures = 0;
    checks_done = 0;
    apb_req_i = '0;
    {nrst_i, vb, wk, kd, lag} = '0;
    cyc(3);
    chk("reset pins", 32'hF8, {24'h0, outs});
    cyc(1);
    nrst_i <= 1'b1;
    cyc(2);
    chkb("oe", 1'b0, pin_oe_n_o);
    rd("ctrl", OFS_CTRL, 32'h0);
    rd("codes", OFS_CODES, 32'hE4);
    rd("ledcfg", OFS_LEDCFG, 32'h3E8);
    rd("unmapped", 12'h010, 32'h0);
    chkb("slverr", 1'b1, rerr);
    vb <= 1'b1;
    cyc(30);
    chk("sense off", 32'h0, pc);
    vb <= 1'b0;
    cyc(30);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      tbl = 8'($random(seed));
      k = (i < 2) ? 2'($random(seed)) : 2'(i - 2);
      bcd = (i != 0);
      lag <= 4'($random(seed));
      apb(1'b1, OFS_CODES, {24'h0, tbl});
      apb(1'b1, OFS_CTRL, {30'h0, 1'b1, bcd});
      kd <= k;
      vb <= 1'b1;
      cyc(40);
      chk("attach", exp_pc(tbl, k, 1'b1, bcd), pc);
      d = exp_pc(tbl, k, 1'b1, bcd);
      apb(1'b1, OFS_CTRL, {28'h0, 2'b10, 1'b1, bcd});
      cyc(3);
      chk("suspend code", {d[31:2], tbl[7:6]}, pc);
      kx = (!bcd || k == PORT_NONE) ? PORT_SDP : k;
      rd("status", OFS_STATUS, {24'h0, kx, 4'b0111, tbl[7:6]});
      vb <= 1'b0;
      cyc(40);
      chk("detach", exp_pc(tbl, k, 1'b0, bcd), pc);
    end
    $display("test charger done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      d = {22'h0, 2'b00, r[1], r[2], 1'b0, r[0], i[1], i[0], 2'b00};
      wk <= i[2] ^ r[2];
      apb(1'b1, OFS_CTRL, d);
      cyc(6);
      chkb("psw", !(i[0] && !i[1]), power_switch_n_o);
      chkb("susp", i[1] || !i[0], suspend_o);
      chkb("wake", i[1] && i[2], remote_wakeup_o);
      chkb("lde", r[0] && r[1], line_driver_enable_o);
    end
    $display("test power done");
    apb(1'b1, OFS_LEDCFG, 32'h6);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, OFS_CTRL, 32'h20 | (32'h100 << j));
      cyc(2);
      chk("led on", 32'h1 << j, leds);
      cyc(12);
      chk("led off", 32'h3, leds);
    end
    $display("test led done");
    nrst_i <= 1'b0;
    cyc(2);
    chkb("oe reset", 1'b1, pin_oe_n_o);
    nrst_i <= 1'b1;
    cyc(3);
    rd("ctrl again", OFS_CTRL, 32'h0);
    $display("test rereset done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
